// ### adcsm_pkg.sv
// register map, field positions, reset values and timing counts of the
// converter setup and mode control block
// assumes a 32-bit APB master; only the low byte of each word is used, except the ten result bits
package adcsm_pkg;

  // byte offsets of the register words
  localparam logic [7:0] OFS_PORT_CFG  = 8'h00; // analog_port_config
  localparam logic [7:0] OFS_P2_DIR    = 8'h04; // port2_direction
  localparam logic [7:0] OFS_PER_EN0   = 8'h08; // peripheral_clock_enable0
  localparam logic [7:0] OFS_MODE_MAIN = 8'h0C; // converter_mode_main
  localparam logic [7:0] OFS_MODE_SEC  = 8'h10; // converter_mode_second
  localparam logic [7:0] OFS_RESULT    = 8'h14; // conversion_result, read only
  localparam logic [7:0] OFS_STATUS    = 8'h18; // done flag, busy, channel
  localparam logic [7:0] OFS_CHAN_SEL  = 8'h1C; // channel for select mode

  // reset values
  localparam logic [7:0] RST_PORT_CFG  = 8'h00;
  localparam logic [7:0] RST_P2_DIR    = 8'hFF;
  localparam logic [7:0] RST_PER_EN0   = 8'h00;
  localparam logic [7:0] RST_MODE_MAIN = 8'h00;
  localparam logic [7:0] RST_MODE_SEC  = 8'h00;
  localparam logic [7:0] RST_CHAN_SEL  = 8'h00;

  // fixed bits of the narrow registers
  localparam logic [7:0] P2_DIR_FIXED  = 8'hF0; // upper nibble reads one
  localparam logic [7:0] PER_EN0_MASK  = 8'hBD; // bits 6 and 1 read zero
  localparam logic [7:0] MODE_SEC_MASK = 8'hE3; // bits 4 to 2 read zero

  // field positions
  localparam int POS_FIRST_PIN_DIR = 0; // first_pin_direction
  localparam int POS_CLK_GATE      = 5; // converter_clock_gate
  localparam int POS_START         = 7; // conversion_start_bit
  localparam int POS_SCAN          = 6; // channel_select_scan_bit
  localparam int POS_DIV_LSB       = 3; // clock divider code, 3 bits
  localparam int POS_TIMING_LSB    = 1; // timing mode, 2 bits
  localparam int POS_CMP_EN        = 0; // comparator_enable
  localparam int POS_TRIG_LSB      = 6; // trigger mode, 2 bits
  localparam int POS_ONESHOT       = 5; // oneshot_select_bit

  // conversion lengths in conversion-clock periods
  localparam logic [4:0] PERIODS_STD1 = 5'h13; // 19 periods
  localparam logic [4:0] PERIODS_STD2 = 5'h11; // 17 periods

  localparam int RESULT_W = 10;   // result width
  localparam int CHAN_N   = 4;    // low analog channels

  typedef enum logic [1:0] {
    ADCSM_TRIG_SW0, ADCSM_TRIG_SW1, ADCSM_TRIG_HW_NOWAIT, ADCSM_TRIG_HW_WAIT
  } adcsm_trig_t;

endpackage

// ### adcsm_clk_div.sv
// conversion clock divider: one-cycle tick every N system clocks
// assumes the divider code is stable while a conversion runs
`timescale 1ns/100ps
`default_nettype none
module adcsm_clk_div (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  output logic            tick
);

  logic [5:0] count;  // system clocks since last tick

  // divisor from the three-bit code
  function automatic logic [5:0] div_ratio(input logic [2:0] code);
    unique case (code)
      3'h0: div_ratio = 6'h3F;  // /64
      3'h1: div_ratio = 6'h1F;  // /32
      3'h2: div_ratio = 6'h0F;  // /16
      3'h3: div_ratio = 6'h07;  // /8
      3'h4: div_ratio = 6'h05;  // /6
      3'h5: div_ratio = 6'h04;  // /5
      3'h6: div_ratio = 6'h03;  // /4
      3'h7: div_ratio = 6'h01;  // /2
    endcase
  endfunction

  // counter restarts whenever run drops, so every conversion is phase aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 6'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 6'h00;
      tick  <= 1'b0;
    end else if (count >= div_ratio(div_code)) begin
      count <= 6'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tick  <= 1'b0;
    end
  end

endmodule // adcsm_clk_div
`default_nettype wire

// ### adcsm_top.sv
// converter setup and mode control: pin assignment, clock gating,
// mode registers and the conversion sequencer, all behind an APB slave
// assumes the analog front end presents a settled code on ANALOG_CODE
// for the channel on CHANNEL_SEL; HW_TRIGGER and ANALOG_CODE are async
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module adcsm_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HW_TRIGGER,
  input  wire logic [9:0]  ANALOG_CODE,
  output logic      [3:0]  ANALOG_ENABLE,
  output logic             FIRST_PIN_OE,
  output logic             CONV_CLK_EN,
  output logic      [1:0]  CHANNEL_SEL,
  output logic             CONV_BUSY,
  output logic             CONV_END_IRQ
);

  // register storage
  logic [7:0] port_cfg;     // analog_port_config
  logic [7:0] p2_dir;       // port2_direction
  logic [7:0] per_en0;      // peripheral_clock_enable0
  logic [7:0] mode_main;    // converter_mode_main
  logic [7:0] mode_sec;     // converter_mode_second
  logic [7:0] chan_sel;     // channel for select mode
  logic [9:0] result;       // conversion_result
  logic       done_flag;    // sticky end-of-conversion flag

  // synchronisers for pin inputs
  logic       trig_s1;      // first stage, feeds trig_s2 only
  logic       trig_s2;
  logic       trig_d;       // delayed for edge detect
  logic [9:0] code_s1;      // first stage, feeds code_s2 only
  logic [9:0] code_s2;

  // bus decode
  logic       acc;          // access phase, answer not yet given
  logic       wr_fire;      // write completes this edge
  logic       mapped;       // address hits a register
  logic [7:0] rd_mux;       // read data selection

  // sequencer
  typedef enum logic {ADCSM_IDLE, ADCSM_CONV} adcsm_state_t;
  adcsm_state_t state;
  logic [4:0] periods;      // conversion clock periods elapsed
  logic [4:0] conv_len;     // periods for this timing mode
  logic       timing_ok;    // timing code is a legal one
  logic       clk_ok;       // input clock supplied and comparator on
  logic       tick;         // conversion clock tick
  logic       trig_edge;    // synchronised trigger rising edge
  logic       go;           // start a conversion this cycle
  logic       finish;       // last period of a conversion
  logic       hw_clear;     // sequencer drops the start bit
  logic       hw_set;       // wait-mode trigger raises the start bit
  logic [1:0] chan;         // channel under conversion

  adcsm_pkg::adcsm_trig_t trig_mode;

  // field extraction
  wire       start_bit = mode_main[adcsm_pkg::POS_START];
  wire       scan_bit  = mode_main[adcsm_pkg::POS_SCAN];
  wire [2:0] div_code  = mode_main[adcsm_pkg::POS_DIV_LSB +: 3];
  wire [1:0] timing    = mode_main[adcsm_pkg::POS_TIMING_LSB +: 2];
  wire       cmp_en    = mode_main[adcsm_pkg::POS_CMP_EN];
  wire       oneshot   = mode_sec[adcsm_pkg::POS_ONESHOT];

  // port config decode; prohibited codes leave every channel digital
  function automatic logic [3:0] analog_map(input logic [2:0] code);
    unique case (code)
      3'h0:    analog_map = 4'hF;  // channels 0 to 3
      3'h1:    analog_map = 4'h0;  // none
      3'h2:    analog_map = 4'h1;  // channel 0
      3'h3:    analog_map = 4'h3;  // channels 0 to 1
      3'h4:    analog_map = 4'h7;  // channels 0 to 2
      default: analog_map = 4'h0;  // prohibited
    endcase
  endfunction

  // apb strobes
  assign acc      = PSEL & PENABLE & ~PREADY;
  assign wr_fire  = PSEL & PENABLE & PREADY & PWRITE;

  // address decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    unique case (PADDR)
      adcsm_pkg::OFS_PORT_CFG:  rd_mux = port_cfg;
      adcsm_pkg::OFS_P2_DIR:    rd_mux = p2_dir;
      adcsm_pkg::OFS_PER_EN0:   rd_mux = per_en0;
      adcsm_pkg::OFS_MODE_MAIN: rd_mux = mode_main;
      adcsm_pkg::OFS_MODE_SEC:  rd_mux = mode_sec;
      adcsm_pkg::OFS_RESULT:    rd_mux = result[7:0];
      adcsm_pkg::OFS_STATUS:    rd_mux = {4'h0, chan, CONV_BUSY, done_flag};
      adcsm_pkg::OFS_CHAN_SEL:  rd_mux = chan_sel;
      default:                  mapped = 1'b0;
    endcase
  end

  // apb answer: one wait state, then ready with data and error
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (acc) begin
      PREADY  <= 1'b1;
      PSLVERR <= ~mapped;
      // result is ten bits wide, so its word carries the top two too
      if (PADDR == adcsm_pkg::OFS_RESULT) begin
        PRDATA <= {22'h00_0000, result};
      end else begin
        PRDATA <= {24'h00_0000, rd_mux};
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // plain configuration registers; fixed bits forced on write
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      port_cfg <= adcsm_pkg::RST_PORT_CFG;
      p2_dir   <= adcsm_pkg::RST_P2_DIR;
      per_en0  <= adcsm_pkg::RST_PER_EN0;
      mode_sec <= adcsm_pkg::RST_MODE_SEC;
      chan_sel <= adcsm_pkg::RST_CHAN_SEL;
    end else if (wr_fire) begin
      unique case (PADDR)
        adcsm_pkg::OFS_PORT_CFG: port_cfg <= {5'h00, PWDATA[2:0]};
        adcsm_pkg::OFS_P2_DIR:
          p2_dir <= PWDATA[7:0] | adcsm_pkg::P2_DIR_FIXED;
        adcsm_pkg::OFS_PER_EN0:
          per_en0 <= PWDATA[7:0] & adcsm_pkg::PER_EN0_MASK;
        adcsm_pkg::OFS_MODE_SEC:
          mode_sec <= PWDATA[7:0] & adcsm_pkg::MODE_SEC_MASK;
        adcsm_pkg::OFS_CHAN_SEL: chan_sel <= {6'h00, PWDATA[1:0]};
        default: ;
      endcase
    end
  end

  // main mode register; a software write beats a hardware update
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_main <= adcsm_pkg::RST_MODE_MAIN;
    end else if (wr_fire && PADDR == adcsm_pkg::OFS_MODE_MAIN) begin
      mode_main <= PWDATA[7:0];
    end else if (hw_set) begin
      mode_main[adcsm_pkg::POS_START] <= 1'b1;
    end else if (hw_clear) begin
      mode_main[adcsm_pkg::POS_START] <= 1'b0;
    end
  end

  // pin input synchronisers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_d  <= 1'b0;
      code_s1 <= 10'h000;
      code_s2 <= 10'h000;
    end else begin
      trig_s1 <= HW_TRIGGER;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
      code_s1 <= ANALOG_CODE;
      code_s2 <= code_s1;
    end
  end

  assign trig_edge = trig_s2 & ~trig_d;
  assign trig_mode = adcsm_pkg::adcsm_trig_t'(mode_sec[adcsm_pkg::POS_TRIG_LSB
                                                       +: 2]);
  assign clk_ok    = per_en0[adcsm_pkg::POS_CLK_GATE] & cmp_en;
  assign timing_ok = (timing[1] == 1'b0);
  assign conv_len  = timing[0] ? adcsm_pkg::PERIODS_STD2
                               : adcsm_pkg::PERIODS_STD1;
  // periods counts earlier ticks, so len-1 marks the last of len periods
  assign finish    = (state == ADCSM_CONV) & tick
                     & (periods == conv_len - 5'h01);

  // start conditions per trigger mode
  always_comb begin
    go     = 1'b0;
    hw_set = 1'b0;
    if (state == ADCSM_IDLE && clk_ok && timing_ok) begin
      unique case (trig_mode)
        adcsm_pkg::ADCSM_TRIG_SW0,
        adcsm_pkg::ADCSM_TRIG_SW1:
          go = start_bit;
        adcsm_pkg::ADCSM_TRIG_HW_NOWAIT:
          go = start_bit & trig_edge;
        adcsm_pkg::ADCSM_TRIG_HW_WAIT: begin
          go     = trig_edge;
          hw_set = trig_edge & ~start_bit;
        end
      endcase
    end
  end

  // start bit falls after one-shot ends, except in no-wait mode, and after every conversion in wait mode
  always_comb begin
    hw_clear = 1'b0;
    if (finish && oneshot) begin
      hw_clear = (trig_mode != adcsm_pkg::ADCSM_TRIG_HW_NOWAIT);
    end
    if (finish && !oneshot && trig_mode == adcsm_pkg::ADCSM_TRIG_HW_WAIT) begin
      hw_clear = 1'b1;
    end
  end

  // conversion clock divider
  adcsm_clk_div u_div (
    .clk      (SYS_CLK),
    .rst_n    (RSTN),
    .run      (state == ADCSM_CONV),
    .div_code (div_code),
    .tick     (tick)
  );

  // sequencer; dropping the start bit or the clock aborts a conversion
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state   <= ADCSM_IDLE;
      periods <= 5'h00;
    end else begin
      unique case (state)
        ADCSM_IDLE: begin
          periods <= 5'h00;
          if (go) begin
            state <= ADCSM_CONV;
          end
        end
        ADCSM_CONV: begin
          if (!clk_ok || !start_bit) begin
            state <= ADCSM_IDLE;
          end else if (finish) begin
            state <= ADCSM_IDLE; // sequential mode restarts from idle
          end else if (tick) begin
            periods <= periods + 5'h01;
          end
        end
      endcase
    end
  end

  // channel stepping: select mode holds, scan mode walks 0 to 3
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      chan <= 2'h0;
    end else if (state == ADCSM_IDLE && !scan_bit) begin
      chan <= chan_sel[1:0];
    end else if (finish && scan_bit) begin
      chan <= chan + 2'h1;
    end else if (state == ADCSM_IDLE && !start_bit) begin
      chan <= 2'h0;
    end
  end

  // result capture, sticky flag and interrupt pulse; set beats clear
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      result       <= 10'h000;
      done_flag    <= 1'b0;
      CONV_END_IRQ <= 1'b0;
    end else begin
      CONV_END_IRQ <= finish;
      if (finish) begin
        result    <= code_s2;
        done_flag <= 1'b1;
      end else if (wr_fire && PADDR == adcsm_pkg::OFS_STATUS
                   && PWDATA[0]) begin
        done_flag <= 1'b0;
      end
    end
  end

  // pin-facing outputs, all registered
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ANALOG_ENABLE <= 4'h0;
      FIRST_PIN_OE  <= 1'b0;
      CONV_CLK_EN   <= 1'b0;
      CHANNEL_SEL   <= 2'h0;
      CONV_BUSY     <= 1'b0;
    end else begin
      ANALOG_ENABLE <= analog_map(port_cfg[2:0]);
      FIRST_PIN_OE  <= ~p2_dir[adcsm_pkg::POS_FIRST_PIN_DIR];
      CONV_CLK_EN   <= per_en0[adcsm_pkg::POS_CLK_GATE];
      CHANNEL_SEL   <= chan;
      CONV_BUSY     <= (state == ADCSM_CONV) | go;
    end
  end

endmodule // adcsm_top
`default_nettype wire

// ### adcsm_properties.sv
// port assertions for the converter setup and mode control block
// assumes one clock domain and the register map of adcsm_pkg
`timescale 1ns/100ps
`default_nettype none
module adcsm_properties (
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [3:0]  ANALOG_ENABLE,
  input wire logic        FIRST_PIN_OE,
  input wire logic        CONV_CLK_EN,
  input wire logic        CONV_BUSY,
  input wire logic        CONV_END_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic        wr_done;   // write completing this cycle
  logic [7:0]  last_wr;   // low byte of the last completed write
  logic [7:0]  main_mode; // last main mode byte written
  logic        trig_hw;   // a hardware trigger mode is chosen
  logic [11:0] run_cnt;   // clocks since start or last completion
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  // analog pin set per port configuration code
  function automatic logic [3:0] port_map(input logic [2:0] c);
    case (c)
      3'h0: return 4'hF;
      3'h2: return 4'h1;
      3'h3: return 4'h3;
      3'h4: return 4'h7;
      default: return 4'h0; // none, or a prohibited code
    endcase
  endfunction
  // timing-mode periods times divider ratio per conversion
  function automatic int conv_clocks(input logic [7:0] m);
    int div [8] = '{64, 32, 16, 8, 6, 5, 4, 2};
    return (m[1] ? 17 : 19) * div[m[5:3]];
  endfunction
  // shadow of what software wrote; hardware changes only touch bit 7
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      last_wr   <= 8'h00;
      main_mode <= 8'h00;
      trig_hw   <= 1'b0;
    end else if (wr_done) begin
      last_wr <= PWDATA[7:0];
      if (PADDR == adcsm_pkg::OFS_MODE_MAIN)
        main_mode <= PWDATA[7:0];
      if (PADDR == adcsm_pkg::OFS_MODE_SEC)
        trig_hw <= PWDATA[7];
    end
  end
  // run length, saturating so a stuck run cannot wrap into the window
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN)
      run_cnt <= 12'h000;
    else if ($rose(CONV_BUSY) || CONV_END_IRQ)
      run_cnt <= 12'h001;
    else if (run_cnt != 12'hFFF)
      run_cnt <= run_cnt + 12'h001;
  end
  chk_apb_wait: assert property (
    $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  chk_port_map: assert property (
    wr_done && PADDR == adcsm_pkg::OFS_PORT_CFG
    |-> ##[1:2] ANALOG_ENABLE == port_map(last_wr[2:0]))
    else $error("analog pin set wrong");
  chk_pin_dir: assert property (
    wr_done && PADDR == adcsm_pkg::OFS_P2_DIR
    |-> ##[1:2] FIRST_PIN_OE == !last_wr[0])
    else $error("first pin buffer wrong");
  chk_clk_gate: assert property (
    wr_done && PADDR == adcsm_pkg::OFS_PER_EN0
    |-> ##[1:2] CONV_CLK_EN == last_wr[5])
    else $error("converter clock gate wrong");
  chk_sw_start: assert property (
    wr_done && PADDR == adcsm_pkg::OFS_MODE_MAIN && PWDATA[7] && PWDATA[0]
    && !PWDATA[2] && CONV_CLK_EN && !trig_hw && !CONV_BUSY
    |-> ##[1:3] CONV_BUSY)
    else $error("start bit did not start");
  chk_conv_len: assert property (
    CONV_END_IRQ |-> int'(run_cnt) >= conv_clocks(main_mode)
    && int'(run_cnt) <= conv_clocks(main_mode) + 4)
    else $error("conversion length off");
  chk_bad_timing: assert property (
    !CONV_BUSY && main_mode[2] |=> !CONV_BUSY)
    else $error("prohibited timing code started");
  chk_irq_pulse: assert property (CONV_END_IRQ |=> !CONV_END_IRQ)
    else $error("end pulse longer than one cycle");
endmodule // adcsm_properties
bind adcsm_top adcsm_properties adcsm_properties_inst (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .ANALOG_ENABLE(ANALOG_ENABLE), .FIRST_PIN_OE(FIRST_PIN_OE),
  .CONV_CLK_EN(CONV_CLK_EN), .CONV_BUSY(CONV_BUSY),
  .CONV_END_IRQ(CONV_END_IRQ)
);
`default_nettype wire

// ### adcsm_analog_src.sv
// analog source model: one settled code per low channel
// assumes the design names the converted channel on its channel output
`timescale 1ns/100ps
`default_nettype none
module adcsm_analog_src #(
  parameter logic [9:0] CODE_BASE = 10'h2A4 // arbitrary test level
) (
  input  wire logic [1:0] channel_sel,   // channel under conversion
  input  wire logic [3:0] analog_enable, // pins given to the converter
  input  wire logic       trigger_req,   // bench asks for a trigger level
  output logic      [9:0] analog_code,   // settled code to the core
  output logic            hw_trigger     // trigger pin level to the design
);
  // channel number in the low bits so a wrong channel shows in the result
  always_comb begin
    analog_code = {CODE_BASE[9:2], channel_sel};
    if (!analog_enable[channel_sel])
      analog_code = ~analog_code; // digital pin carries no level
  end
  assign hw_trigger = trigger_req;
endmodule // adcsm_analog_src
`default_nettype wire

// ### adc_setup_and_mode_control_tb.sv
// self-checking bench for the converter setup and mode control block
// assumes adcsm_pkg, adcsm_top, the source model and checker are compiled
`timescale 1ns/100ps
`default_nettype none
module adc_setup_and_mode_control_tb;
  localparam logic [9:0] BASE = 10'h2A4; // arbitrary analog level
  logic        sys_clk = 1'b0;           // 50 MHz clock
  logic        rstn    = 1'b0;           // reset, active low
  logic        psel    = 1'b0;           // apb select
  logic        penable = 1'b0;           // apb access phase
  logic        pwrite  = 1'b0;           // apb direction
  logic [7:0]  paddr   = 8'h00;          // apb byte address
  logic [31:0] pwdata  = 32'h0000_0000;  // apb write data
  logic [31:0] prdata, rd;               // read data, last word read
  logic        pready, pslverr, err;     // answer, error, last error
  logic        hw_trig, oe, clk_en, busy, irq; // pin and status outputs
  logic        trig_req = 1'b0;          // trigger level asked of model
  logic [9:0]  acode;                    // model to design
  logic [3:0]  an_en;                    // analog pin set
  logic [1:0]  chan;                     // channel under conversion
  int          error_cnt  = 0;           // mismatches
  int          n_compared = 0;           // comparisons made
  adcsm_top adcsm_top_inst (
    .SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .HW_TRIGGER(hw_trig),
    .ANALOG_CODE(acode), .ANALOG_ENABLE(an_en), .FIRST_PIN_OE(oe),
    .CONV_CLK_EN(clk_en), .CHANNEL_SEL(chan), .CONV_BUSY(busy),
    .CONV_END_IRQ(irq));
  adcsm_analog_src #(.CODE_BASE(BASE)) adcsm_analog_src_inst (
    .channel_sel(chan), .analog_enable(an_en), .analog_code(acode),
    .hw_trigger(hw_trig), .trigger_req(trig_req));
  // free-running clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; waits for pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    chk("pready", 32'h0000_0001, 32'(pready));
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // bounded wait for the end pulse
  task automatic wait_irq(input int cap, output int cyc);
    cyc = 0;
    do begin
      @(posedge sys_clk);
      cyc++;
    end while (irq !== 1'b1 && cyc < cap);
  endtask
  task automatic t_reset;
    rdchk("port_cfg", adcsm_pkg::OFS_PORT_CFG, 32'h0000_0000);
    rdchk("p2_dir", adcsm_pkg::OFS_P2_DIR, 32'h0000_00FF);
    rdchk("per_en0", adcsm_pkg::OFS_PER_EN0, 32'h0000_0000);
    rdchk("mode_main", adcsm_pkg::OFS_MODE_MAIN, 32'h0000_0000);
    chk("pin_oe", 32'h0000_0000, 32'(oe));
    apb(1'b1, 8'h20, 32'h0000_00FF);
    rdchk("unmapped", 8'h20, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, 32'(err));
    $display("t_reset done");
  endtask
  task automatic t_port;
    logic [3:0] tbl [8] = '{4'hF, 4'h0, 4'h1, 4'h3, 4'h7, 4'h0, 4'h0, 4'h0};
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, adcsm_pkg::OFS_PORT_CFG, 32'(c));
      @(posedge sys_clk);
      chk("analog_enable", 32'(tbl[c]), 32'(an_en));
    end
    apb(1'b1, adcsm_pkg::OFS_PORT_CFG, 32'h0000_0000);
    $display("t_port done");
  endtask
  task automatic t_pin;
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, adcsm_pkg::OFS_P2_DIR, 32'(b));
      apb(1'b1, adcsm_pkg::OFS_PER_EN0, 32'(b ? 8'h00 : 8'hFF));
      // the gate output follows the write by one more edge
      @(posedge sys_clk);
      chk("pin_oe", 32'(b == 0), 32'(oe));
      chk("clk_en", 32'(b == 0), 32'(clk_en));
    end
    rdchk("p2_dir", adcsm_pkg::OFS_P2_DIR, 32'h0000_00F1);
    apb(1'b1, adcsm_pkg::OFS_PER_EN0, 32'h0000_0020);
    $display("t_pin done");
  endtask
  // every divider code, both timing modes, one-shot, select mode
  task automatic t_conv;
    int cyc, exp, got;
    logic [7:0] m;
    int div [8] = '{64, 32, 16, 8, 6, 5, 4, 2};
    apb(1'b1, adcsm_pkg::OFS_MODE_SEC, 32'h0000_0020);
    for (int d = 0; d < 8; d++) begin
      m = {2'b10, 3'(d), 1'b0, 1'(d), 1'b1};
      exp = (d % 2 ? 17 : 19) * div[d];
      apb(1'b1, adcsm_pkg::OFS_CHAN_SEL, 32'(d % 4));
      apb(1'b1, adcsm_pkg::OFS_MODE_MAIN, 32'(m));
      wait_irq(2000, cyc);
      // a few clocks of start and capture latency on top of the periods
      got = (cyc >= exp && cyc <= exp + 4) ? exp : cyc;
      chk("conv_clocks", 32'(exp), 32'(got));
      repeat (4) @(posedge sys_clk);
      chk("busy", 32'h0000_0000, 32'(busy));
      rdchk("result", adcsm_pkg::OFS_RESULT,
            32'({BASE[9:2], 2'(d)}));
      rdchk("status", adcsm_pkg::OFS_STATUS,
            32'((d % 4) * 4 + 1));
      rdchk("mode_main", adcsm_pkg::OFS_MODE_MAIN,
            32'(m & 8'h7F));
      apb(1'b1, adcsm_pkg::OFS_STATUS, 32'h0000_0001);
    end
    $display("t_conv done");
  endtask
  // sequential scan over the four channels, then a stop
  task automatic t_scan;
    int cyc;
    apb(1'b1, adcsm_pkg::OFS_MODE_SEC, 32'h0000_0000);
    apb(1'b1, adcsm_pkg::OFS_CHAN_SEL, 32'h0000_0000);
    apb(1'b1, adcsm_pkg::OFS_MODE_MAIN, 32'h0000_00F9);
    for (int i = 0; i < 5; i++) begin
      wait_irq(200, cyc);
      chk("scan_irq", 32'h0000_0001, 32'(irq));
      rdchk("scan_result", adcsm_pkg::OFS_RESULT,
            32'({BASE[9:2], 2'(i)}));
    end
    apb(1'b1, adcsm_pkg::OFS_MODE_MAIN, 32'h0000_0079);
    wait_irq(200, cyc);
    chk("stop_irq", 32'h0000_0000, 32'(irq));
    $display("t_scan done");
  endtask
  // prohibited timing codes must never start
  task automatic t_bad;
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, adcsm_pkg::OFS_MODE_MAIN, 32'(8'h85 | 8'(t * 2)));
      repeat (40) @(posedge sys_clk);
      chk("bad_timing_busy", 32'h0000_0000, 32'(busy));
    end
    $display("t_bad done");
  endtask
  // hardware wait mode: trigger edge sets start, one shot, start drops
  task automatic t_hw;
    int cyc;
    apb(1'b1, adcsm_pkg::OFS_MODE_SEC, 32'h0000_00E0);
    apb(1'b1, adcsm_pkg::OFS_MODE_MAIN, 32'h0000_0039);
    repeat (8) @(posedge sys_clk);
    chk("hw_idle_busy", 32'h0000_0000, 32'(busy));
    trig_req <= 1'b1;
    wait_irq(200, cyc);
    chk("hw_irq", 32'h0000_0001, 32'(irq));
    trig_req <= 1'b0;
    rdchk("hw_result", adcsm_pkg::OFS_RESULT,
          32'({BASE[9:2], 2'h0}));
    rdchk("hw_mode", adcsm_pkg::OFS_MODE_MAIN, 32'h0000_0039);
    $display("t_hw done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_port();
    t_pin();
    t_conv();
    t_scan();
    t_bad();
    t_hw();
    end_of_test();
  end
  // hang guard, well past the expected run of under 10000 cycles
  initial begin
    #400_000;
    error_cnt++;
    end_of_test();
  end
endmodule // adc_setup_and_mode_control_tb
`default_nettype wire
